// ===== tb_top.sv
`timescale 1ns/1ns
// self-checking bench for the monitor and enable windows
module tb_top
   import tdm_mon_pkg::*;
;
   logic             sys_clk = 1'b0;
   logic             reset   = 1'b1;
   logic             ce      = 1'b1;
   logic [31:0][1:0] groupRate;
   tdm_host_req_t    hostReq;
   tdm_rx_byte_t     rxByte;
   tdm_ber_evt_t     berEvt;
   logic             cntClear;
   logic [6:0]       cntClearSel;
   logic [6:0]       cntReadSel;
   logic             hostAck;
   logic [7:0]       hostReadData;
   logic             busErrorN;
   logic [15:0]      berCount;
   int               failCount = 0;
   int               nChecks   = 0;
   int               cnt[128];

   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;

   // clock enable driven by the bench; one scenario freezes the block
   tdm_mon_top uut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .groupRate(groupRate),
      .hostReq(hostReq), .rxByte(rxByte), .berEvt(berEvt), .cntClear(cntClear),
      .cntClearSel(cntClearSel), .cntReadSel(cntReadSel), .hostAck(hostAck),
      .hostReadData(hostReadData), .busErrorN(busErrorN), .berCount(berCount));

   tdm_host_model host (.sys_clk(sys_clk), .hostAck(hostAck), .busErrorN(busErrorN),
      .hostReadData(hostReadData), .hostReq(hostReq));

   ////////////////////////////////////////////////////////////////////////////////////////
   // verdict and run end, shared by the main sequence and the bounded waits
   task automatic conclude;
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // comparisons, one per kind of result
   task automatic chk_status(string nm, int e, int g);
      nChecks++;
      if (e != g)
      begin
         $display("unexpected %s expected %0d seen %0d", nm, e, g);
         failCount++;
      end
      if (g == 2)
         conclude();
   endtask : chk_status

   task automatic chk_data(string nm, logic [7:0] e, logic [7:0] g);
      nChecks++;
      if (e !== g)
      begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         failCount++;
      end
   endtask : chk_data

   task automatic chk_count(string nm, logic [15:0] e, logic [15:0] g);
      nChecks++;
      if (e !== g)
      begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         failCount++;
      end
   endtask : chk_count

   ////////////////////////////////////////////////////////////////////////////////////////
   // one host access with expected status and, for good reads, expected byte
   task automatic acc(logic wr, logic [17:0] a, logic [7:0] wd, int es, logic [7:0] ed);
      int         st;
      logic [7:0] rd;
      host.access(wr, a, wd, st, rd);
      chk_status("access status", es, st);
      if (es == 0 && !wr)
         chk_data("read data", ed, rd);
   endtask : acc

   // one received byte on the receive path
   task automatic rx(logic [4:0] g, logic [1:0] s, logic [9:0] sl, logic [7:0] d);
      @(posedge sys_clk);
      rxByte <= '{1'b1, g, s, sl, d};
      @(posedge sys_clk);
      rxByte.valid <= 1'b0;
   endtask : rx

   // one single-bit error event; the counter shows two edges later
   task automatic ev(int g, int s, int sl);
      @(posedge sys_clk);
      berEvt     <= '{1'b1, 5'(g), 2'(s), 10'(sl), 1'b1};
      cntReadSel <= 7'(g * 4 + s);
      @(posedge sys_clk);
      berEvt.valid <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask : ev

   ////////////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      int          g;
      int          s;
      int          sl;
      int          r;
      int          off;
      int          idx;
      logic [7:0]  d;
      logic        en;
      logic [17:0] da;
      logic [17:0] ea;
      rxByte      = '0;
      berEvt      = '0;
      cntClear    = 1'b0;
      cntClearSel = 7'h00;
      cntReadSel  = 7'h00;
      foreach (cnt[i])
         cnt[i] = 0;
      // every rate code in use before any window is touched
      for (int i = 0; i < 32; i++)
         groupRate[i] = 2'(i);
      void'($urandom(32'hfc060735));
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk_data("busErrorN after reset", 8'h01, {7'h00, busErrorN});
      chk_count("berCount after reset", 16'h0000, berCount);
      // random timeslots over all groups and rates
      for (int k = 0; k < 40; k++)
      begin
         g   = $urandom_range(31, 0);
         r   = g % 4;
         s   = $urandom_range((r == 3) ? 0 : (r == 2) ? 1 : 3, 0);
         sl  = $urandom_range((128 << r) - 1, 0);
         off = s * (128 << r) + sl;
         da  = TDM_DATA_BASE + 18'(g * 'h400 + off);
         ea  = TDM_EN_BASE + 18'(g * 'h400 + off);
         d   = 8'($urandom);
         en  = 1'($urandom);
         idx = g * 4 + s;
         rx(5'(g), 2'(s), 10'(sl), d);
         acc(1'b0, da, 8'h00, 0, d);
         acc(1'b1, da, d, 1, 8'h00);
         acc(1'b1, ea, {7'($urandom), en}, 0, 8'h00);
         acc(1'b0, ea, 8'h00, 0, {7'h00, en});
         ev(g, s, sl);
         if (en && cnt[idx] < 65535)
            cnt[idx]++;
         chk_count("berCount", 16'(cnt[idx]), berCount);
      end
      // top corners of both regions
      rx(5'd31, 2'd0, 10'h3ff, 8'h5a);
      acc(1'b0, 18'h2ffff, 8'h00, 0, 8'h5a);
      acc(1'b1, 18'h37fff, 8'h01, 0, 8'h00);
      acc(1'b0, 18'h37fff, 8'h00, 0, 8'h01);
      // upper half of an 8 Mbps group and places outside both regions
      acc(1'b0, TDM_DATA_BASE + 18'h200 + 18'($urandom_range(511, 0)), 8'h00, 1, 8'h00);
      acc(1'b1, TDM_EN_BASE + 18'h13ff, 8'h01, 1, 8'h00);
      acc(1'b0, 18'h27fff, 8'h00, 1, 8'h00);
      acc(1'b0, 18'h38000, 8'h00, 1, 8'h00);
      // saturation: a stream of errors longer than the counter range, then a clear
      acc(1'b1, TDM_EN_BASE + 18'h0c05, 8'h01, 0, 8'h00);
      @(posedge sys_clk);
      berEvt     <= '{1'b1, 5'd3, 2'd0, 10'd5, 1'b1};
      cntReadSel <= 7'd12;
      repeat (65540) @(posedge sys_clk);
      berEvt.valid <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk_count("berCount saturated", 16'hffff, berCount);
      @(posedge sys_clk);
      cntClear    <= 1'b1;
      cntClearSel <= 7'd12;
      @(posedge sys_clk);
      cntClear <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk_count("berCount cleared", 16'h0000, berCount);
      // clock enable low: an enabled error slot must not count while frozen
      @(posedge sys_clk);
      ce     <= 1'b0;
      berEvt <= '{1'b1, 5'd3, 2'd0, 10'd5, 1'b1};
      repeat (3) @(posedge sys_clk);
      berEvt.valid <= 1'b0;
      ce           <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk_count("berCount frozen", 16'h0000, berCount);
      conclude();
   end
endmodule : tb_top

// ===== tdm_ber_counter.sv
`timescale 1ns/1ns
// saturating 16-bit error counter of one input stream
module tdm_ber_counter
   import tdm_mon_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic        inc,
   input  wire logic        clr,
   output logic     [15:0]  count
);

   ////////////////////////////////////////////////////////////////////////////////
   // a clear and an error in the same cycle leave a count of one: no error lost
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         count <= TDM_CNT_RESET;
      else if (ce)
      begin
         if (clr)
            count <= inc ? 16'h0001 : TDM_CNT_RESET;
         else if (inc && count != TDM_CNT_MAX)
            count <= count + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_cnt_sat;
      @(posedge sys_clk) disable iff (reset || !ce)
      (count == TDM_CNT_MAX && !clr) |=> (count == TDM_CNT_MAX);
   endproperty
   a_cnt_sat : assert property (p_cnt_sat) else $error("counter left saturation");

   property p_cnt_inc;
      @(posedge sys_clk) disable iff (reset || !ce)
      (inc && !clr && count != TDM_CNT_MAX) |=> (count == $past(count) + 16'h0001);
   endproperty
   a_cnt_inc : assert property (p_cnt_inc) else $error("counter missed an error");

   property p_cnt_hold;
      @(posedge sys_clk) disable iff (reset || !ce)
      (!inc && !clr) |=> $stable(count);
   endproperty
   a_cnt_hold : assert property (p_cnt_hold) else $error("counter moved without error");

endmodule : tdm_ber_counter

// ===== tdm_host_model.sv
`timescale 1ns/1ns
// host processor on the parallel bus: request held until ack or bus error is sampled
module tdm_host_model
   import tdm_mon_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       hostAck,
   input  wire logic       busErrorN,
   input  wire logic [7:0] hostReadData,
   output tdm_host_req_t   hostReq
);
   // bus idle from time zero
   initial hostReq = '0;

   ////////////////////////////////////////////////////////////////////////////////////////
   // st: 0 ack, 1 bus error, 2 no answer in bound, 3 ack and error together
   task automatic access(input logic wr, input logic [17:0] a, input logic [7:0] wd,
                         output int st, output logic [7:0] rd);
      st = 2;
      rd = 8'h00;
      @(posedge sys_clk);
      hostReq <= '{valid: 1'b1, write: wr, addr: a, wdata: wd};
      // the answer is sampled at the edge; the request stands until then
      for (int i = 0; i < 6; i++)
      begin
         @(posedge sys_clk);
         if (hostAck === 1'b1 || busErrorN === 1'b0)
         begin
            st = (hostAck === 1'b1) ? ((busErrorN === 1'b1) ? 0 : 3) : 1;
            rd = hostReadData;
            break;
         end
      end
      // released lines change pattern so a stale address cannot pass for a held one
      hostReq <= '{valid: 1'b0, write: 1'b0, addr: ~a, wdata: ~wd};
   endtask : access
endmodule : tdm_host_model

// ===== tdm_mon_pkg.sv
// Function
// - Host can read the byte received in every input timeslot from a data window.
// - Each of 32 groups gets a 1024-byte data window, spaced 400 hex from 028000.
// - 65 Mbps maps only stream zero; 32 Mbps maps two 512-slot streams.
// - 16 Mbps maps four 256-slot blocks; 8 Mbps maps four 128-slot blocks.
// - At 8 Mbps offsets 200-3FF of a group are unmapped and answer bus error.
// - Address is group start plus stream offset; timeslots map one address each.
// - Host writes into the data window are refused with the active-low bus error.
// - A read/write enable memory holds one location per incoming timeslot.
// - Enable windows start at 030000, one 1024-byte window per group, 400 hex apart.
// - Each enable location holds a single counting-enable bit at data bit zero.
// - A stream's error counter counts only in timeslots whose enable bit is set.
// - Enable memory uses the same rate-dependent layout, including the 8 Mbps hole.
// - Each stream counter counts single-bit errors and saturates at 65535 until cleared.
package tdm_mon_pkg;

   // address map of the two windows, 18-bit byte addresses
   localparam logic [17:0] TDM_DATA_BASE  = 18'h28000;
   localparam logic [17:0] TDM_EN_BASE    = 18'h30000;
   localparam int          TDM_REG_MSB    = 17;   // region select field
   localparam int          TDM_REG_LSB    = 15;
   localparam int          TDM_GRP_MSB    = 14;   // group field, window of 400 hex
   localparam int          TDM_GRP_LSB    = 10;
   localparam int          TDM_OFF_MSB    = 9;    // offset inside a group window
   localparam int          TDM_HALF_BIT   = 9;    // offset bit set from 200 hex upward
   localparam int          TDM_EN_BIT     = 0;    // data bit that carries the enable

   // input rate codes as delivered by the group control logic
   localparam logic [1:0]  TDM_RATE_8     = 2'h0;
   localparam logic [1:0]  TDM_RATE_16    = 2'h1;
   localparam logic [1:0]  TDM_RATE_32    = 2'h2;
   localparam logic [1:0]  TDM_RATE_65    = 2'h3;

   // sizes
   localparam int          TDM_GROUPS     = 32;
   localparam int          TDM_STREAMS    = 128;
   localparam int          TDM_MEM_DEPTH  = 32768;
   localparam logic [15:0] TDM_CNT_MAX    = 16'hffff;
   localparam logic [15:0] TDM_CNT_RESET  = 16'h0000;
   localparam logic [7:0]  TDM_BYTE_RESET = 8'h00;

   typedef enum logic {TDM_ACC_IDLE, TDM_ACC_ANSWER} tdm_acc_state_t;

   // host access request, valid held until the answer is sampled
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [17:0] addr;
      logic [7:0]  wdata;
   } tdm_host_req_t;

   // byte received in one timeslot of one stream
   typedef struct packed {
      logic       valid;
      logic [4:0] group;
      logic [1:0] stream;
      logic [9:0] slot;
      logic [7:0] data;
   } tdm_rx_byte_t;

   // error check result of one timeslot
   typedef struct packed {
      logic       valid;
      logic [4:0] group;
      logic [1:0] stream;
      logic [9:0] slot;
      logic       bitError;
   } tdm_ber_evt_t;

endpackage : tdm_mon_pkg

// ===== tdm_mon_top.sv
`timescale 1ns/1ns
// receive data monitor window and per-timeslot error count enable window
module tdm_mon_top
   import tdm_mon_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic             ce,
   input  wire logic [31:0][1:0] groupRate,
   input  wire tdm_host_req_t    hostReq,
   input  wire tdm_rx_byte_t     rxByte,
   input  wire tdm_ber_evt_t     berEvt,
   input  wire logic             cntClear,
   input  wire logic [6:0]       cntClearSel,
   input  wire logic [6:0]       cntReadSel,
   output logic                  hostAck,
   output logic      [7:0]       hostReadData,
   output logic                  busErrorN,
   output logic      [15:0]      berCount
);

   ////////////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0]           dataMem [TDM_MEM_DEPTH];
   logic [TDM_MEM_DEPTH-1:0] enMem_r;
   tdm_acc_state_t       accState_r;
   tdm_acc_state_t       accState_nxt;
   logic [14:0]          lastIdx_r;
   logic                 lastWasEn_r;

   // host decode
   logic                 reqTake;
   logic                 inData;
   logic                 inEn;
   logic [4:0]           reqGroup;
   logic [9:0]           reqOff;
   logic [14:0]          reqIdx;
   logic [1:0]           reqRate;
   logic                 reqHole;
   logic                 reqError;

   // receive and error-check paths
   logic [9:0]           rxOff;
   logic                 rxMapped;
   logic [14:0]          rxIdx;
   logic [9:0]           berOff;
   logic                 berMapped;
   logic [14:0]          berIdx;
   logic                 berHit;
   logic [6:0]           berStream;
   logic [TDM_STREAMS-1:0][15:0] cntValue;

   // helpers read by the checks only
   logic [7:0]           dataAtReq;
   logic                 enAtLast;

   ////////////////////////////////////////////////////////////////////////////////
   // window select: the region field alone tells the two windows apart
   function automatic logic tdm_in_region(input logic [17:0] addr,
                                          input logic [17:0] base);
      return (addr[TDM_REG_MSB:TDM_REG_LSB] == base[TDM_REG_MSB:TDM_REG_LSB]);
   endfunction : tdm_in_region

   // flat storage index of one timeslot: group above the window offset,
   // shared by host, receive and error paths so all three agree on layout
   function automatic logic [14:0] tdm_slot_index(input logic [4:0] grp,
                                                  input logic [9:0] off);
      return {grp, off};
   endfunction : tdm_slot_index

   ////////////////////////////////////////////////////////////////////////////////
   // host address decode: region, group and offset fields
   assign reqTake  = ce && hostReq.valid && (accState_r == TDM_ACC_IDLE);
   assign inData   = tdm_in_region(hostReq.addr, TDM_DATA_BASE);
   assign inEn     = tdm_in_region(hostReq.addr, TDM_EN_BASE);
   assign reqGroup = hostReq.addr[TDM_GRP_MSB:TDM_GRP_LSB];
   assign reqOff   = hostReq.addr[TDM_OFF_MSB:0];
   assign reqIdx   = tdm_slot_index(reqGroup, reqOff);
   assign reqRate  = groupRate[reqGroup];

   // the 8 Mbps upper half is a hole in both windows; a rate change is not
   // tracked here, so software must set the rate before touching a window
   assign reqHole  = (reqRate == TDM_RATE_8) && reqOff[TDM_HALF_BIT];

   // refused: write to the data window, the hole, or outside both windows
   assign reqError = !(inData || inEn) || reqHole
                     || (inData && hostReq.write);

   ////////////////////////////////////////////////////////////////////////////////
   // stream/slot to window offset, shared layout for both windows
   tdm_stream_map u_rx_map
   (
      .rate   (groupRate[rxByte.group]),
      .stream (rxByte.stream),
      .slot   (rxByte.slot),
      .offset (rxOff),
      .mapped (rxMapped)
   );

   tdm_stream_map u_ber_map
   (
      .rate   (groupRate[berEvt.group]),
      .stream (berEvt.stream),
      .slot   (berEvt.slot),
      .offset (berOff),
      .mapped (berMapped)
   );

   assign rxIdx     = tdm_slot_index(rxByte.group, rxOff);
   assign berIdx    = tdm_slot_index(berEvt.group, berOff);
   assign berStream = {berEvt.group, berEvt.stream};

   ////////////////////////////////////////////////////////////////////////////////
   // host access sequencer: one answer cycle after each taken request
   always_comb
   begin
      accState_nxt = accState_r;
      case (accState_r)
         TDM_ACC_IDLE:
            if (reqTake)
               accState_nxt = TDM_ACC_ANSWER;
         TDM_ACC_ANSWER:
            accState_nxt = TDM_ACC_IDLE;
         default:
            accState_nxt = TDM_ACC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         accState_r <= TDM_ACC_IDLE;
      else if (ce)
         accState_r <= accState_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // answer: acknowledge, read data and bus error, each for one cycle
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         hostAck      <= 1'b0;
         busErrorN    <= 1'b1;
         hostReadData <= TDM_BYTE_RESET;
         lastIdx_r    <= 15'h0000;
         lastWasEn_r  <= 1'b0;
      end
      else if (ce)
      begin
         hostAck   <= reqTake && !reqError;
         busErrorN <= !(reqTake && reqError);
         if (reqTake)
         begin
            lastIdx_r   <= reqIdx;
            lastWasEn_r <= inEn;
         end
         if (reqTake && !reqError && !hostReq.write)
         begin
            if (inData)
               hostReadData <= dataMem[reqIdx];
            else
               hostReadData <= {7'h00, enMem_r[reqIdx]};
         end
         else
            hostReadData <= TDM_BYTE_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // data memory: latest byte of each timeslot, rewritten every frame
   // left without reset on purpose; its contents are data, not control
   always_ff @(posedge sys_clk)
   begin
      if (ce && rxByte.valid && rxMapped)
         dataMem[rxIdx] <= rxByte.data;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // enable memory: one bit per timeslot, written by the host
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         enMem_r <= '0;
      else if (ce && reqTake && inEn && hostReq.write && !reqError)
         enMem_r[reqIdx] <= hostReq.wdata[TDM_EN_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // error counters, gated per timeslot by the enable bit
   assign berHit = berEvt.valid && berEvt.bitError && berMapped
                   && enMem_r[berIdx];

   for (genvar s = 0; s < TDM_STREAMS; s++)
   begin : g_cnt
      tdm_ber_counter u_cnt
      (
         .sys_clk (sys_clk),
         .reset   (reset),
         .ce      (ce),
         .inc     (berHit && (berStream == 7'(s))),
         .clr     (cntClear && (cntClearSel == 7'(s))),
         .count   (cntValue[s])
      );
   end

   // registered readout keeps the top output on a flip-flop
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         berCount <= TDM_CNT_RESET;
      else if (ce)
         berCount <= cntValue[cntReadSel];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   assign dataAtReq = dataMem[reqIdx];
   assign enAtLast  = enMem_r[lastIdx_r];

   sequence s_take_data_write;
      reqTake && inData && hostReq.write;
   endsequence

   sequence s_error_pulse;
      !busErrorN ##1 busErrorN;
   endsequence

   sequence s_ack_pulse;
      hostAck ##1 !hostAck;
   endsequence

   property p_data_write_err;
      @(posedge sys_clk) disable iff (reset || !ce)
      s_take_data_write |=> (!busErrorN && !hostAck);
   endproperty
   a_data_write_err : assert property (p_data_write_err)
      else $error("data window write not refused");

   property p_hole_err;
      @(posedge sys_clk) disable iff (reset || !ce)
      (reqTake && (inData || inEn) && groupRate[reqGroup] == TDM_RATE_8
       && reqOff[TDM_HALF_BIT]) |=> s_error_pulse;
   endproperty
   a_hole_err : assert property (p_hole_err)
      else $error("8 Mbps upper half not refused");

   property p_hole_16_ok;
      @(posedge sys_clk) disable iff (reset || !ce)
      (reqTake && inEn && groupRate[reqGroup] == TDM_RATE_16) |=> (busErrorN && hostAck);
   endproperty
   a_hole_16_ok : assert property (p_hole_16_ok)
      else $error("enable window refused at 16 Mbps");

   property p_read_data;
      @(posedge sys_clk) disable iff (reset || !ce)
      (reqTake && inData && !hostReq.write && !reqHole)
         |=> (hostAck && hostReadData == $past(dataAtReq));
   endproperty
   a_read_data : assert property (p_read_data)
      else $error("data read returned wrong byte");

   property p_en_upper_zero;
      @(posedge sys_clk) disable iff (reset || !ce)
      (hostAck && lastWasEn_r) |-> (hostReadData[7:1] == 7'h00);
   endproperty
   a_en_upper_zero : assert property (p_en_upper_zero)
      else $error("enable read has upper bits set");

   property p_en_write;
      @(posedge sys_clk) disable iff (reset || !ce)
      (reqTake && inEn && hostReq.write && !reqHole)
         |=> (enAtLast == $past(hostReq.wdata[TDM_EN_BIT]));
   endproperty
   a_en_write : assert property (p_en_write)
      else $error("enable bit not stored");

   property p_answer_once;
      @(posedge sys_clk) disable iff (reset || !ce)
      hostAck |-> (s_ack_pulse and ($past(reqTake) ##1 1'b1));
   endproperty
   a_answer_once : assert property (p_answer_once)
      else $error("acknowledge not a single answer");

   // looks at the counter itself, so a broken gate anywhere on the path shows
   property p_gate_off;
      @(posedge sys_clk) disable iff (reset || !ce)
      (berEvt.valid && berMapped && !enMem_r[berIdx] && !cntClear)
         |=> (cntValue[$past(berStream)] == $past(cntValue[berStream]));
   endproperty
   a_gate_off : assert property (p_gate_off)
      else $error("count while enable clear");

   property p_never_both;
      @(posedge sys_clk) disable iff (reset || !ce)
      !(hostAck && !busErrorN);
   endproperty
   a_never_both : assert property (p_never_both)
      else $error("acknowledge and bus error together");

   property p_idle_quiet;
      @(posedge sys_clk) disable iff (reset || !ce)
      (!reqTake) |=> (busErrorN && !hostAck && hostReadData == TDM_BYTE_RESET);
   endproperty
   a_idle_quiet : assert property (p_idle_quiet)
      else $error("answer without a taken request");

   // a refused write into the hole must leave the stored bit alone
   property p_hole_en_write;
      @(posedge sys_clk) disable iff (reset || !ce)
      (reqTake && inEn && hostReq.write && reqHole)
         |=> (enAtLast == $past(enMem_r[reqIdx]));
   endproperty
   a_hole_en_write : assert property (p_hole_en_write)
      else $error("enable write landed in the hole");

endmodule : tdm_mon_top

// ===== tdm_stream_map.sv
`timescale 1ns/1ns
// turns stream and timeslot into the offset inside a group window
module tdm_stream_map
   import tdm_mon_pkg::*;
(
   input  wire logic [1:0] rate,
   input  wire logic [1:0] stream,
   input  wire logic [9:0] slot,
   output logic      [9:0] offset,
   output logic            mapped
);

   ////////////////////////////////////////////////////////////////////////////////
   // rate-dependent stream blocks, slots linear inside each block
   always_comb
   begin
      offset = 10'h000;
      mapped = 1'b0;
      case (rate)
         TDM_RATE_65:
         begin
            offset = slot;
            mapped = (stream == 2'h0);
         end
         TDM_RATE_32:
         begin
            offset = {stream[0], slot[8:0]};
            mapped = !stream[1] && !slot[9];
         end
         TDM_RATE_16:
         begin
            offset = {stream, slot[7:0]};
            mapped = (slot[9:8] == 2'h0);
         end
         TDM_RATE_8:
         begin
            offset = {1'b0, stream, slot[6:0]};
            mapped = (slot[9:7] == 3'h0);                     // upper half never reached
         end
         default:
         begin
            offset = 10'h000;
            mapped = 1'b0;
         end
      endcase
   end

endmodule : tdm_stream_map
